//--- logic/adcctl_pkg.sv
// Package with register map, field positions, reset values and timing for the converter control.
package adcctl_pkg;
    // Register byte addresses on the AXI4-Lite slave.
    localparam logic [4:0] ADCCTL_OFF_RES_LOW = 5'h00;
    localparam logic [4:0] ADCCTL_OFF_RES_HIGH = 5'h04;
    localparam logic [4:0] ADCCTL_OFF_MAIN = 5'h08;
    localparam logic [4:0] ADCCTL_OFF_AUX = 5'h0c;
    localparam logic [4:0] ADCCTL_OFF_PIN_LOW = 5'h10;
    localparam logic [4:0] ADCCTL_OFF_PIN_HIGH = 5'h14;
    // Main control field positions.
    localparam int ADCCTL_MAIN_START = 7;
    localparam int ADCCTL_MAIN_BUSY = 6;
    localparam int ADCCTL_MAIN_POFF = 5;
    localparam int ADCCTL_MAIN_FMT = 4;
    // Aux control field positions.
    localparam int ADCCTL_AUX_BGSEL = 7;
    localparam int ADCCTL_AUX_BGEN = 6;
    localparam int ADCCTL_AUX_REFSEL = 4;
    // Writable masks; the rest reads as zero.
    localparam logic [7:0] ADCCTL_AUX_MASK = 8'hd7;
    localparam logic [7:0] ADCCTL_PINH_MASK = 8'h03;
    // Reset values.
    localparam logic [7:0] ADCCTL_MAIN_RST = 8'h60;
    localparam logic [7:0] ADCCTL_AUX_RST = 8'h00;
    // Conversion length in converter clock cycles.
    localparam logic [3:0] ADCCTL_CONV_CYCLES = 4'hd;
    localparam logic [3:0] ADCCTL_CH_LAST = 4'h9;
    localparam logic [1:0] ADCCTL_RESP_OKAY = 2'h0;
    localparam logic [1:0] ADCCTL_RESP_SLVERR = 2'h2;

    // Conversion sequencer states.
    typedef enum logic [1:0] {ADCCTL_IDLE, ADCCTL_RESET, ADCCTL_CONV} adcctl_state_t;

    // Analog front-end controls driven to the converter macro.
    typedef struct packed {
        logic power_on;
        logic conv_reset;
        logic sample_start;
        logic bandgap_route;
        logic [3:0] channel;
        logic ext_channel_en;
        logic bandgap_enable;
        logic bandgap_ref_on;
        logic ext_ref_sel;
        logic [9:0] analog_pin_enables;
    } adcctl_ana_t;

    // Whole state of the block.
    typedef struct packed {
        adcctl_state_t st;
        logic [7:0] main;
        logic [7:0] aux;
        logic [7:0] pinl;
        logic [7:0] pinh;
        logic [11:0] result;
        logic [6:0] div_cnt;
        logic [3:0] conv_cnt;
        logic done;
        logic awv;
        logic [4:0] awaddr;
        logic wv;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic awready;
        logic wready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        adcctl_ana_t ana;
    } adcctl_reg_t;
endpackage

//--- logic/adcctl_top.sv
// Converter control logic: AXI4-Lite registers, start sequencing, clock divider, alignment.
`timescale 1ns/1ps
`default_nettype none
module adcctl_top (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [4:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [4:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    output logic s_axi_rready_in_unused_out,
    input wire logic s_axi_rready_in,
    input wire logic [11:0] conv_data_in,
    input wire logic low_voltage_monitor_en_in,
    output adcctl_pkg::adcctl_ana_t ana_out,
    output logic conv_done_out
);
    import adcctl_pkg::*;

    adcctl_reg_t q;  // Registered state.
    adcctl_reg_t d;  // Next state.
    logic div_tick;  // One converter clock period has elapsed.
    logic [6:0] div_limit;  // Terminal count of the divider.
    logic [7:0] rd_low;  // Aligned low result byte.
    logic [7:0] rd_high;  // Aligned high result byte.
    logic start_bit;  // Current start bit.
    logic wr_go;  // Write address and data both held.
    logic [7:0] wbyte;  // Lane zero of the write data.

    // Alignment of the stored result into the two byte views.
    always_comb begin
        if (q.main[ADCCTL_MAIN_FMT]) begin
            rd_high = {4'h0, q.result[11:8]};
            rd_low = q.result[7:0];
        end else begin
            rd_high = q.result[11:4];
            rd_low = {q.result[3:0], 4'h0};
        end
    end

    // Divider terminal count; the undefined code behaves as divide by one.
    always_comb begin
        case (q.aux[2:0])
            3'h1: div_limit = 7'h01;
            3'h2: div_limit = 7'h03;
            3'h3: div_limit = 7'h07;
            3'h4: div_limit = 7'h0f;
            3'h5: div_limit = 7'h1f;
            3'h6: div_limit = 7'h3f;
            default: div_limit = 7'h00;
        endcase
    end
    assign div_tick = (q.div_cnt >= div_limit);
    assign start_bit = q.main[ADCCTL_MAIN_START];
    assign wr_go = q.awv && q.wv && !q.bvalid;
    assign wbyte = q.wdata[7:0];

    // Next-state logic for the bus slave, the sequencer and the front end.
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.awready = 1'b0;
        d.wready = 1'b0;
        d.arready = 1'b0;
        // Write address and data are captured independently, in either order.
        if (!q.awv && s_axi_awvalid_in && !q.awready) begin
            d.awv = 1'b1;
            d.awaddr = s_axi_awaddr_in;
            d.awready = 1'b1;
        end
        if (!q.wv && s_axi_wvalid_in && !q.wready) begin
            d.wv = 1'b1;
            d.wdata = s_axi_wdata_in;
            d.wstrb = s_axi_wstrb_in;
            d.wready = 1'b1;
        end
        if (q.bvalid && s_axi_bready_in) begin
            d.bvalid = 1'b0;
        end
        // Register write; only lane zero holds data, upper lanes ignored.
        if (wr_go) begin
            d.awv = 1'b0;
            d.wv = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = ADCCTL_RESP_OKAY;
            case (q.awaddr)
                ADCCTL_OFF_MAIN: begin
                    if (q.wstrb[0]) begin
                        // Busy bit kept; software cannot write it.
                        d.main = {wbyte[7], q.main[ADCCTL_MAIN_BUSY], wbyte[5:0]};
                    end
                end
                ADCCTL_OFF_AUX: begin
                    if (q.wstrb[0]) begin
                        d.aux = wbyte & ADCCTL_AUX_MASK;
                    end
                end
                ADCCTL_OFF_PIN_LOW: begin
                    if (q.wstrb[0]) begin
                        d.pinl = wbyte;
                    end
                end
                ADCCTL_OFF_PIN_HIGH: begin
                    if (q.wstrb[0]) begin
                        d.pinh = wbyte & ADCCTL_PINH_MASK;
                    end
                end
                ADCCTL_OFF_RES_LOW, ADCCTL_OFF_RES_HIGH: begin
                    d.bresp = ADCCTL_RESP_OKAY;  // Read-only; write ignored.
                end
                default: begin
                    d.bresp = ADCCTL_RESP_SLVERR;  // Unmapped address.
                end
            endcase
        end
        // Read channel: one read at a time, answer one cycle after address.
        if (q.rvalid && s_axi_rready_in) begin
            d.rvalid = 1'b0;
        end
        if (!q.rvalid && !q.arready && s_axi_arvalid_in) begin
            d.arready = 1'b1;
            d.rvalid = 1'b1;
            d.rresp = ADCCTL_RESP_OKAY;
            case (s_axi_araddr_in)
                ADCCTL_OFF_RES_LOW: d.rdata = {24'h0, rd_low};
                ADCCTL_OFF_RES_HIGH: d.rdata = {24'h0, rd_high};
                ADCCTL_OFF_MAIN: d.rdata = {24'h0, q.main};
                ADCCTL_OFF_AUX: d.rdata = {24'h0, q.aux};
                ADCCTL_OFF_PIN_LOW: d.rdata = {24'h0, q.pinl};
                ADCCTL_OFF_PIN_HIGH: d.rdata = {24'h0, q.pinh};
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = ADCCTL_RESP_SLVERR;
                end
            endcase
        end
        // Converter clock divider runs freely, whether powered or not.
        // It is never gated, so a conversion's first tick may fall anywhere in one period.
        d.div_cnt = div_tick ? 7'h00 : q.div_cnt + 7'h01;
        // Start sequencing; power-off aborts any activity.
        case (q.st)
            ADCCTL_IDLE: begin
                if (start_bit && !q.main[ADCCTL_MAIN_POFF]) begin
                    d.st = ADCCTL_RESET;
                end
            end
            ADCCTL_RESET: begin
                d.main[ADCCTL_MAIN_BUSY] = 1'b1;
                if (!start_bit) begin
                    d.st = ADCCTL_CONV;
                    d.conv_cnt = 4'h0;
                end
            end
            ADCCTL_CONV: begin
                if (start_bit) begin
                    d.st = ADCCTL_RESET;  // Restart aborts the running conversion.
                end else if (div_tick) begin
                    if (q.conv_cnt == ADCCTL_CONV_CYCLES - 4'h1) begin
                        d.result = conv_data_in;
                        d.st = ADCCTL_IDLE;
                    end else begin
                        d.conv_cnt = q.conv_cnt + 4'h1;
                    end
                end
            end
            default: d.st = ADCCTL_IDLE;
        endcase
        // Busy clears in the same cycle as the result is stored.
        if (q.st == ADCCTL_CONV && d.st == ADCCTL_IDLE) begin
            d.main[ADCCTL_MAIN_BUSY] = 1'b0;
            d.done = 1'b1;
        end
        if (start_bit && q.st == ADCCTL_IDLE) begin
            d.main[ADCCTL_MAIN_BUSY] = 1'b1;
        end
        // Power-off drops the sequencer to idle; an abort raises no done event.
        if (q.main[ADCCTL_MAIN_POFF] && q.st != ADCCTL_IDLE) begin
            d.st = ADCCTL_IDLE;
        end
        // Front-end controls are registered so the outputs come from flops.
        d.ana.power_on = !d.main[ADCCTL_MAIN_POFF];
        d.ana.conv_reset = (d.st != ADCCTL_CONV);
        d.ana.sample_start = (q.st == ADCCTL_RESET) && (d.st == ADCCTL_CONV);
        d.ana.bandgap_route = d.aux[ADCCTL_AUX_BGSEL];
        d.ana.ext_channel_en = !d.aux[ADCCTL_AUX_BGSEL];
        d.ana.channel = (d.main[3:0] > ADCCTL_CH_LAST) ? ADCCTL_CH_LAST : d.main[3:0];
        d.ana.bandgap_enable = d.aux[ADCCTL_AUX_BGEN];
        d.ana.bandgap_ref_on = d.aux[ADCCTL_AUX_BGEN] || low_voltage_monitor_en_in;
        d.ana.ext_ref_sel = d.aux[ADCCTL_AUX_REFSEL];
        d.ana.analog_pin_enables = {d.pinh[1:0], d.pinl};
    end

    // Single state register.
    // The reset branch loads constants only, so the converter starts held in reset.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q <= '0;
            q.st <= ADCCTL_IDLE;
            q.main <= ADCCTL_MAIN_RST;
            q.aux <= ADCCTL_AUX_RST;
            q.ana.conv_reset <= 1'b1;
            q.ana.ext_channel_en <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready_out = q.awready;
    assign s_axi_wready_out = q.wready;
    assign s_axi_bvalid_out = q.bvalid;
    assign s_axi_bresp_out = q.bresp;
    assign s_axi_arready_out = q.arready;
    assign s_axi_rvalid_out = q.rvalid;
    assign s_axi_rdata_out = q.rdata;
    assign s_axi_rresp_out = q.rresp;
    assign s_axi_rready_in_unused_out = q.rvalid;
    assign ana_out = q.ana;
    assign conv_done_out = q.done;

    // Busy must be high whenever the sequencer holds the converter in reset.
    property p_busy_in_reset;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (q.st == ADCCTL_RESET) |=> q.main[ADCCTL_MAIN_BUSY];
    endproperty
    a_busy_in_reset: assert property (p_busy_in_reset) else $error("busy low in reset");

    // A conversion only begins after the start bit falls.
    property p_start_seq;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        q.ana.sample_start |-> $past(q.st) == ADCCTL_RESET && !start_bit;
    endproperty
    a_start_seq: assert property (p_start_seq) else $error("start without fall");

    // Done pulse coincides with busy falling.
    property p_done_busy;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        q.done |-> !q.main[ADCCTL_MAIN_BUSY] && $past(q.main[ADCCTL_MAIN_BUSY]);
    endproperty
    a_done_busy: assert property (p_done_busy) else $error("done without busy fall");

    // Result is stored when the conversion completes.
    property p_result_first;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        q.done |-> q.result == $past(conv_data_in);
    endproperty
    a_result_first: assert property (p_result_first) else $error("result not stored");

    // Channel output never exceeds input nine.
    property p_channel_cap;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        q.ana.channel == ((q.main[3:0] > 4'h9) ? 4'h9 : q.main[3:0]);
    endproperty
    a_channel_cap: assert property (p_channel_cap) else $error("bad channel");

    // Bandgap routing excludes external inputs.
    property p_bg_route;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        q.ana.bandgap_route |-> !q.ana.ext_channel_en;
    endproperty
    a_bg_route: assert property (p_bg_route) else $error("external left connected");

    // Power follows the power-off bit.
    // Both are registered from the same next value, so they agree in every cycle.
    property p_power;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        q.ana.power_on == !q.main[ADCCTL_MAIN_POFF];
    endproperty
    a_power: assert property (p_power) else $error("power mismatch");

    // Reference stays on while the monitor is enabled.
    property p_bg_ref;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        $past(low_voltage_monitor_en_in) |-> q.ana.bandgap_ref_on;
    endproperty
    a_bg_ref: assert property (p_bg_ref) else $error("reference off");

    // Unused aligned result bits read zero.
    property p_align_zero;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (q.main[ADCCTL_MAIN_FMT] ? rd_high[7:4] : rd_low[3:0]) == 4'h0;
    endproperty
    a_align_zero: assert property (p_align_zero) else $error("unused bits set");

    // Busy stays high for the whole conversion.
    property p_busy_conv;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (q.st == ADCCTL_CONV) |-> q.main[ADCCTL_MAIN_BUSY];
    endproperty
    a_busy_conv: assert property (p_busy_conv) else $error("busy low while converting");

    // The end event is a single-cycle pulse.
    property p_done_pulse;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        q.done |=> !q.done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

    // The stored result only changes together with the end event.
    property p_result_hold;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        !q.done |-> $stable(q.result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved without done");

    // The sample strobe to the converter lasts one cycle only.
    property p_sample_pulse;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        q.ana.sample_start |=> !q.ana.sample_start;
    endproperty
    a_sample_pulse: assert property (p_sample_pulse) else $error("sample strobe too long");

    c_conv_done: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) q.done);
    c_restart: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
        q.st == ADCCTL_CONV ##1 q.st == ADCCTL_RESET);
    c_bg: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) q.ana.bandgap_route);
    c_fmt_one: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
        q.done && q.main[ADCCTL_MAIN_FMT]);
endmodule
`default_nettype wire

//--- tb/adcctl_tb_top.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adcctl_pkg::*;
    // Bench-driven inputs, all given a value at time zero.
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [4:0] araddr = 5'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [11:0] conv_data = 12'h000;
    logic lvm_en = 1'b0;
    // Design outputs.
    logic awready, wready, bvalid, arready, rvalid, done;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rdata, rd_data;
    adcctl_ana_t ana;
    // Counters kept by the bench.
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int done_cnt = 0;
    int t_done = 0;
    int ss_cnt = 0;

    adcctl_top DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in_unused_out(), .s_axi_rready_in(rready), .conv_data_in(conv_data),
        .low_voltage_monitor_en_in(lvm_en), .ana_out(ana), .conv_done_out(done));

    // A 200 MHz system clock.
    always #2.5 clk_sys_in = ~clk_sys_in;

    // Cycle count and end-of-conversion monitor; the done pulse lasts one cycle only.
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (done === 1'b1) begin
            done_cnt <= done_cnt + 1;
            t_done <= cyc;
        end
        if (ana.sample_start === 1'b1) begin
            ss_cnt <= ss_cnt + 1;
        end
    end

    // Compare one value and report a mismatch at once.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Register write; address and data are held until each is taken.
    task automatic axi_wr(input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 60) begin
            @(posedge clk_sys_in);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                last_resp = bresp;
                n = 100;
            end
        end
        bready <= 1'b0;
        chk("write response seen", 1, n == 100);
    endtask

    // Register read; the data is taken at the edge where rvalid is seen.
    task automatic axi_rd(input logic [4:0] a);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 60) begin
            @(posedge clk_sys_in);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rd_data = rdata;
                last_resp = rresp;
                n = 100;
            end
        end
        rready <= 1'b0;
        chk("read response seen", 1, n == 100);
    endtask

    // Read a register and compare it with the model's byte.
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string name);
        axi_rd(a);
        chk("read response okay", ADCCTL_RESP_OKAY, last_resp);
        chk(name, {24'h0, exp}, rd_data);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog sized well above the longest conversion sequence.
    initial begin
        repeat (30000) @(posedge clk_sys_in);
        errors++;
        finish_test();
    end

    // Main sequence.
    initial begin
        int dv, t0, n0, n;
        logic fmt;
        logic [7:0] pl, exp_hi, exp_lo;
        logic [11:0] rv;
        logic [11:0] exp_q[$];
        void'($urandom(32'ha4e42848));
        repeat (12) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        rd_chk(ADCCTL_OFF_MAIN, 8'h60, "main reset value");
        rd_chk(ADCCTL_OFF_AUX, 8'h00, "aux reset value");
        chk("powered down after reset", 0, ana.power_on);
        // Masks of unimplemented bits, pin enables and reference controls.
        pl = 8'($urandom());
        axi_wr(ADCCTL_OFF_PIN_LOW, pl);
        axi_wr(ADCCTL_OFF_PIN_HIGH, 8'hff);
        axi_wr(ADCCTL_OFF_AUX, 8'h40);
        axi_wr(ADCCTL_OFF_AUX, 8'hff);
        rd_chk(ADCCTL_OFF_AUX, 8'hd7, "aux unused bits zero");
        rd_chk(ADCCTL_OFF_PIN_HIGH, 8'h03, "pin high unused bits");
        rd_chk(ADCCTL_OFF_PIN_LOW, pl, "pin low");
        chk("pin enables", {22'h0, 2'b11, pl}, 32'(ana.analog_pin_enables));
        chk("external reference", 1, ana.ext_ref_sel);
        chk("bandgap enable", 1, ana.bandgap_enable);
        for (int l = 0; l < 2; l++) begin
            lvm_en <= l[0];
            axi_wr(ADCCTL_OFF_AUX, 8'h00);
            repeat (3) @(posedge clk_sys_in);
            chk("bandgap reference", l, ana.bandgap_ref_on);
            chk("bandgap grounded", 0, ana.bandgap_enable);
            chk("supply reference", 0, ana.ext_ref_sel);
        end
        axi_rd(5'h18);
        chk("unmapped response", ADCCTL_RESP_SLVERR, last_resp);
        chk("unmapped data", 0, rd_data);
        // One conversion per divider code, alternating the result format.
        for (int i = 0; i < 8; i++) begin
            dv = (i == 0 || i == 7) ? 1 : (1 << i);
            fmt = i[0];
            rv = 12'($urandom());
            conv_data <= rv;
            exp_q.push_back(rv);  // Model queue of results still to come.
            axi_wr(ADCCTL_OFF_AUX, 8'(i)); // Bandgap stays off, so no settling wait.
            axi_wr(ADCCTL_OFF_MAIN, {3'b100, fmt, 4'h0});
            rd_chk(ADCCTL_OFF_MAIN, {3'b110, fmt, 4'h0}, "busy while start high");
            chk("converter held in reset", 1, ana.conv_reset);
            chk("converter powered", 1, ana.power_on);
            n0 = done_cnt;
            repeat (40) @(posedge clk_sys_in);
            chk("no conversion while start high", n0, done_cnt);
            axi_wr(ADCCTL_OFF_MAIN, {3'b000, fmt, 4'h0});
            t0 = cyc;
            rd_chk(ADCCTL_OFF_MAIN, {3'b010, fmt, 4'h0}, "busy during conversion");
            chk("converter released", 0, ana.conv_reset);
            n = 0;
            while (done_cnt == n0 && n < 2000) begin
                @(posedge clk_sys_in);
                n++;
            end
            repeat (2) @(posedge clk_sys_in);
            chk("single done pulse", n0 + 1, done_cnt);
            chk("one sample start per conversion", done_cnt, ss_cnt);
            n = t_done - t0 - int'(ADCCTL_CONV_CYCLES - 4'h1) * dv;
            chk("conversion length", 1, n >= 0 && n <= dv + 2);
            rv = exp_q.pop_front();
            exp_hi = fmt ? {4'h0, rv[11:8]} : rv[11:4];
            exp_lo = fmt ? rv[7:0] : {rv[3:0], 4'h0};
            rd_chk(ADCCTL_OFF_RES_HIGH, exp_hi, "result high");
            rd_chk(ADCCTL_OFF_RES_LOW, exp_lo, "result low");
            rd_chk(ADCCTL_OFF_MAIN, {3'b000, fmt, 4'h0}, "busy cleared");
        end
        // Result registers are read-only.
        axi_wr(ADCCTL_OFF_RES_HIGH, 8'hff);
        chk("read-only write response", ADCCTL_RESP_OKAY, last_resp);
        rd_chk(ADCCTL_OFF_RES_HIGH, exp_hi, "result not writable");
        // Start raised again mid-conversion restarts it; one done follows the final fall.
        n0 = done_cnt;
        axi_wr(ADCCTL_OFF_MAIN, 8'h90);
        axi_wr(ADCCTL_OFF_MAIN, 8'h10);
        axi_wr(ADCCTL_OFF_MAIN, 8'h90);
        repeat (40) @(posedge clk_sys_in);
        chk("restart holds off done", n0, done_cnt);
        axi_wr(ADCCTL_OFF_MAIN, 8'h10);
        repeat (40) @(posedge clk_sys_in);
        chk("restart ends once", n0 + 1, done_cnt);
        rd_chk(ADCCTL_OFF_MAIN, 8'h10, "busy cleared after restart");
        // Channel decode without the bandgap routed in; routing checked with and without it.
        for (int b = 0; b < 2; b++) begin
            axi_wr(ADCCTL_OFF_AUX, b ? 8'hc0 : 8'h40);
            for (int c = 0; c < 16; c++) begin
                axi_wr(ADCCTL_OFF_MAIN, 8'h40 | 8'(c));
                repeat (3) @(posedge clk_sys_in);
                chk("bandgap route", b, ana.bandgap_route);
                chk("external inputs", b == 0, ana.ext_channel_en);
                if (b == 0) chk("channel", (c > 9) ? 9 : c, 32'(ana.channel));
            end
        end
        rd_chk(ADCCTL_OFF_MAIN, 8'h0f, "busy not writable");
        axi_wr(ADCCTL_OFF_MAIN, 8'h20);
        repeat (3) @(posedge clk_sys_in);
        chk("power off", 0, ana.power_on);
        finish_test();
    end
endmodule
`default_nettype wire
